// ### hw/oag_top.sv
// Operand effective-address generator for a 16-bit core
//
// How it works
// - File-direct operand address is the 13-bit instruction field, near region.
// - File instructions use register zero as implied working operand.
// - Move instruction uses a full 16-bit address over whole data space.
// - Three-operand form: base register direct, second register or literal.
// - Literal field decoded as 5-bit or 10-bit by the request.
// - Register-direct returns register contents, no memory access.
// - Indirect uses pointer contents unmodified as address.
// - Post-modified uses old pointer, then writes back adjusted pointer.
// - Pre-modified adjusts pointer, writes it back, uses new value.
// - Register-indexed address is pointer plus base, no write-back.
// - Literal-offset address is pointer plus instruction literal.
// - Table address is page bits 7..0 above pointer effective address.
// - Low table accesses move bits 15..0, word or byte.
// - High table accesses move bits 23..16, word or byte.
`timescale 1ns/1ps
module oag_top #(
    parameter int DATA_W = 16,
    parameter int IDX_W = 4
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Operand request
    input wire logic REQ_VALID,
    input wire logic [3:0] REQ_MODE,
    input wire logic [IDX_W-1:0] PTR_IDX,
    input wire logic [IDX_W-1:0] BASE_IDX,
    input wire logic [12:0] FILE_ADDR,
    input wire logic [15:0] FULL_ADDR,
    input wire logic [9:0] LIT_FIELD,
    input wire logic LIT_LONG,
    input wire logic BYTE_OP,
    input wire logic [1:0] TBL_KIND,
    // Working register write from the core
    input wire logic REG_WE,
    input wire logic [IDX_W-1:0] REG_WIDX,
    input wire logic [DATA_W-1:0] REG_WDATA,
    // Table page register load
    input wire logic PAGE_WE,
    input wire logic [7:0] PAGE_WDATA,
    // Results
    output logic RES_VALID,
    output logic MEM_ACCESS,
    output logic [15:0] DATA_ADDR,
    output logic [15:0] OPERAND,
    output logic [15:0] BASE_OPERAND,
    output logic [15:0] IMPLIED_OPERAND,
    output logic PROG_ACCESS,
    output logic [23:0] PROG_ADDR,
    output logic PROG_HIGH,
    output logic PROG_WRITE,
    output logic PROG_BYTE,
    output logic [23:0] PROG_LANE_MASK
);
    // ------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------
    // Register reads take one cycle, so the request is held one stage.
    logic busy_r;
    logic [3:0] mode_r;
    logic [IDX_W-1:0] ptr_idx_r;
    logic [12:0] file_r;
    logic [15:0] full_r;
    logic [9:0] lit_r;
    logic lit_long_r;
    logic byte_r;
    logic [1:0] tbl_r;
    logic [7:0] page_r;
    logic [DATA_W-1:0] ptr_val;
    logic [DATA_W-1:0] base_val;
    logic [DATA_W-1:0] acc_val;
    logic [IDX_W-1:0] rb_sel;

    // Implied register zero is read on port B for file instructions
    assign rb_sel = (REQ_MODE == 4'(oag_pkg::OAG_FILE_DIRECT)) ?
        oag_pkg::OAG_DEFAULT_REG : BASE_IDX;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            busy_r <= 1'b0;
            mode_r <= 4'h0;
            ptr_idx_r <= '0;
            file_r <= 13'h0000;
            full_r <= 16'h0000;
            lit_r <= 10'h000;
            lit_long_r <= 1'b0;
            byte_r <= 1'b0;
            tbl_r <= 2'h0;
        end else begin
            busy_r <= REQ_VALID;
            if (REQ_VALID) begin
                mode_r <= REQ_MODE;
                ptr_idx_r <= PTR_IDX;
                file_r <= FILE_ADDR;
                full_r <= FULL_ADDR;
                lit_r <= LIT_FIELD;
                lit_long_r <= LIT_LONG;
                byte_r <= BYTE_OP;
                tbl_r <= TBL_KIND;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            page_r <= oag_pkg::OAG_PAGE_RESET;
        end else if (PAGE_WE) begin
            page_r <= PAGE_WDATA;
        end
    end

    // ------------------------------------------------------------
    // Pointer arithmetic
    // ------------------------------------------------------------
    function automatic logic [15:0] lit_decode(input logic [9:0] f,
                                               input logic long_sel);
        logic [15:0] v;
        v = 16'h0000;
        if (long_sel) begin
            v = {6'h00, f};
        end else begin
            v = {11'h000, f[4:0]};
        end
        return v;
    endfunction

    wire [15:0] step = byte_r ? oag_pkg::OAG_STEP_BYTE
                              : oag_pkg::OAG_STEP_WORD;
    wire [15:0] ptr_inc = 16'(ptr_val + step);
    wire [15:0] ptr_dec = 16'(ptr_val - step);
    wire [15:0] lit_val = lit_decode(lit_r, lit_long_r);
    wire [15:0] idx_sum = 16'(ptr_val + base_val);
    wire [15:0] lit_sum = 16'(ptr_val + lit_val);

    logic [15:0] ea;
    logic mem_acc;
    logic [15:0] opnd;
    logic wb_en;
    logic [15:0] wb_val;

    always_comb begin
        ea = 16'h0000;
        mem_acc = 1'b0;
        opnd = 16'h0000;
        wb_en = 1'b0;
        wb_val = ptr_val;
        case (mode_r)
            4'(oag_pkg::OAG_FILE_DIRECT): begin
                ea = {3'h0, file_r};
                mem_acc = 1'b1;
            end
            4'(oag_pkg::OAG_MOVE_FULL): begin
                ea = full_r;
                mem_acc = 1'b1;
            end
            4'(oag_pkg::OAG_REG_DIRECT): begin
                opnd = ptr_val;
            end
            4'(oag_pkg::OAG_LITERAL): begin
                opnd = lit_val;
            end
            4'(oag_pkg::OAG_IND), 4'(oag_pkg::OAG_TABLE): begin
                ea = ptr_val;
                mem_acc = (mode_r == 4'(oag_pkg::OAG_IND));
            end
            4'(oag_pkg::OAG_IND_POST_INC): begin
                ea = ptr_val;
                mem_acc = 1'b1;
                wb_en = 1'b1;
                wb_val = ptr_inc;
            end
            4'(oag_pkg::OAG_IND_POST_DEC): begin
                ea = ptr_val;
                mem_acc = 1'b1;
                wb_en = 1'b1;
                wb_val = ptr_dec;
            end
            4'(oag_pkg::OAG_IND_PRE_INC): begin
                ea = ptr_inc;
                mem_acc = 1'b1;
                wb_en = 1'b1;
                wb_val = ptr_inc;
            end
            4'(oag_pkg::OAG_IND_PRE_DEC): begin
                ea = ptr_dec;
                mem_acc = 1'b1;
                wb_en = 1'b1;
                wb_val = ptr_dec;
            end
            4'(oag_pkg::OAG_IND_REG_OFS): begin
                ea = idx_sum;
                mem_acc = 1'b1;
            end
            4'(oag_pkg::OAG_IND_LIT_OFS): begin
                ea = lit_sum;
                mem_acc = 1'b1;
            end
            default: begin
                ea = 16'h0000;
            end
        endcase
    end

    // Pointer write-back wins over a core write in the same cycle
    wire rf_we = (busy_r && wb_en) || REG_WE;
    wire [IDX_W-1:0] rf_widx = (busy_r && wb_en) ? ptr_idx_r : REG_WIDX;
    wire [15:0] rf_wdata = (busy_r && wb_en) ? wb_val : REG_WDATA;

    oag_regfile #(
        .DATA_W(DATA_W),
        .IDX_W(IDX_W),
        .DEPTH(oag_pkg::OAG_NUM_REGS)
    ) u_regs (
        .CLK(CLK),
        .RSTN(RSTN),
        .ra_idx(PTR_IDX),
        .ra_data(ptr_val),
        .rb_idx(rb_sel),
        .rb_data(base_val),
        .we(rf_we),
        .w_idx(rf_widx),
        .w_data(rf_wdata)
    );

    // Implied register zero is the base read port value, shared with the base operand
    assign acc_val = base_val;

    // ------------------------------------------------------------
    // Table address formation
    // ------------------------------------------------------------
    wire is_tbl = busy_r && (mode_r == 4'(oag_pkg::OAG_TABLE));
    wire tbl_high = tbl_r[1];
    wire tbl_wr = tbl_r[0];
    wire [23:0] tbl_addr = {page_r, ptr_val};
    // Byte lane chosen by address bit 0 on the low word
    wire [23:0] low_mask = byte_r ? (ptr_val[0] ? 24'h00ff00 : 24'h0000ff)
                                  : 24'h00ffff;
    wire [23:0] high_mask = 24'hff0000;
    wire [23:0] lane_mask = tbl_high ? high_mask : low_mask;

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            RES_VALID <= 1'b0;
            MEM_ACCESS <= 1'b0;
            DATA_ADDR <= 16'h0000;
            OPERAND <= 16'h0000;
            BASE_OPERAND <= 16'h0000;
            IMPLIED_OPERAND <= 16'h0000;
            PROG_ACCESS <= 1'b0;
            PROG_ADDR <= 24'h000000;
            PROG_HIGH <= 1'b0;
            PROG_WRITE <= 1'b0;
            PROG_BYTE <= 1'b0;
            PROG_LANE_MASK <= 24'h000000;
        end else begin
            RES_VALID <= busy_r;
            MEM_ACCESS <= busy_r && mem_acc;
            PROG_ACCESS <= is_tbl;
            if (busy_r) begin
                DATA_ADDR <= ea;
                OPERAND <= opnd;
                BASE_OPERAND <= base_val;
                IMPLIED_OPERAND <= acc_val;
                PROG_ADDR <= tbl_addr;
                PROG_HIGH <= tbl_high;
                PROG_WRITE <= tbl_wr;
                PROG_BYTE <= byte_r;
                PROG_LANE_MASK <= is_tbl ? lane_mask : 24'h000000;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_file_near: assert property (@(posedge CLK) disable iff (!RSTN)
        busy_r && mode_r == 4'h0 |=> MEM_ACCESS && DATA_ADDR[15:13] == 3'h0
        && DATA_ADDR[12:0] == $past(file_r)) else $error("file addr");
    a_reg_direct: assert property (@(posedge CLK) disable iff (!RSTN)
        busy_r && mode_r == 4'h1 |=> !MEM_ACCESS && OPERAND == $past(ptr_val))
        else $error("reg direct");
    a_ind_plain: assert property (@(posedge CLK) disable iff (!RSTN)
        busy_r && mode_r == 4'h2 |=> DATA_ADDR == $past(ptr_val))
        else $error("indirect");
    a_post_inc: assert property (@(posedge CLK) disable iff (!RSTN)
        busy_r && mode_r == 4'h3 && !byte_r |=>
        DATA_ADDR == 16'($past(rf_wdata) - 16'h0002))
        else $error("post inc");
    a_pre_dec: assert property (@(posedge CLK) disable iff (!RSTN)
        busy_r && mode_r == 4'h6 |=> DATA_ADDR == $past(rf_wdata)
        && $past(rf_we)) else $error("pre dec");
    a_idx_sum: assert property (@(posedge CLK) disable iff (!RSTN)
        busy_r && mode_r == 4'h7 |-> !wb_en ##1
        DATA_ADDR == 16'($past(ptr_val) + $past(base_val)))
        else $error("indexed");
    a_lit_ofs: assert property (@(posedge CLK) disable iff (!RSTN)
        busy_r && mode_r == 4'h8 && !lit_long_r |=>
        DATA_ADDR == 16'($past(ptr_val) + {11'h000, $past(lit_r[4:0])}))
        else $error("lit offset");
    a_tbl_addr: assert property (@(posedge CLK) disable iff (!RSTN)
        is_tbl |=> PROG_ACCESS && PROG_ADDR[23:16] == $past(page_r)
        && PROG_ADDR[15:0] == $past(ptr_val)) else $error("table");
    a_tbl_high: assert property (@(posedge CLK) disable iff (!RSTN)
        is_tbl && tbl_high |=> PROG_LANE_MASK == 24'hff0000)
        else $error("high lanes");
    a_tbl_low: assert property (@(posedge CLK) disable iff (!RSTN)
        is_tbl && !tbl_high && !byte_r |=> PROG_LANE_MASK == 24'h00ffff)
        else $error("low lanes");
    a_step_byte: assert property (@(posedge CLK) disable iff (!RSTN)
        busy_r && mode_r == 4'h5 && byte_r |->
        rf_wdata == 16'(ptr_val + 16'h0001)) else $error("step");
    a_move_full: assert property (@(posedge CLK) disable iff (!RSTN)
        busy_r && mode_r == 4'ha |=> DATA_ADDR == $past(full_r))
        else $error("move");
    a_lit_long: assert property (@(posedge CLK) disable iff (!RSTN)
        busy_r && mode_r == 4'h9 && lit_long_r |=>
        OPERAND == {6'h00, $past(lit_r)}) else $error("literal");
endmodule

// ### hw/oag_pkg.sv
// Shared constants and types for the operand address generator
package oag_pkg;
    // Mode encodings of an operand request
    typedef enum logic [3:0] {
        OAG_FILE_DIRECT  = 4'h0,
        OAG_REG_DIRECT   = 4'h1,
        OAG_IND          = 4'h2,
        OAG_IND_POST_INC = 4'h3,
        OAG_IND_POST_DEC = 4'h4,
        OAG_IND_PRE_INC  = 4'h5,
        OAG_IND_PRE_DEC  = 4'h6,
        OAG_IND_REG_OFS  = 4'h7,
        OAG_IND_LIT_OFS  = 4'h8,
        OAG_LITERAL      = 4'h9,
        OAG_MOVE_FULL    = 4'ha,
        OAG_TABLE        = 4'hb
    } oag_mode_e;

    // Table access kinds
    typedef enum logic [1:0] {
        OAG_TBL_READ_LOW   = 2'h0,
        OAG_TBL_WRITE_LOW  = 2'h1,
        OAG_TBL_READ_HIGH  = 2'h2,
        OAG_TBL_WRITE_HIGH = 2'h3
    } oag_tbl_e;

    localparam int OAG_DATA_W = 16;
    localparam int OAG_NEAR_W = 13;
    localparam int OAG_PROG_W = 24;
    localparam int OAG_PAGE_W = 8;
    localparam int OAG_REG_IDX_W = 4;
    localparam int OAG_NUM_REGS = 16;
    localparam int OAG_LIT_SHORT_W = 5;
    localparam int OAG_LIT_LONG_W = 10;
    localparam logic [3:0] OAG_DEFAULT_REG = 4'h0;
    localparam logic [15:0] OAG_STEP_BYTE = 16'h0001;
    localparam logic [15:0] OAG_STEP_WORD = 16'h0002;
    localparam logic [15:0] OAG_REG_RESET = 16'h0000;
    localparam logic [7:0] OAG_PAGE_RESET = 8'h00;
    localparam int OAG_LOW_LSB = 0;
    localparam int OAG_HIGH_LSB = 16;
    localparam int OAG_HIGH_W = 8;
    localparam int OAG_RESULT_LAT = 1;
endpackage

// ### hw/oag_regfile.sv
// Working register file with two registered read ports and one write port
`timescale 1ns/1ps
module oag_regfile #(
    parameter int DATA_W = 16,
    parameter int IDX_W = 4,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Read ports
    input wire logic [IDX_W-1:0] ra_idx,
    output logic [DATA_W-1:0] ra_data,
    input wire logic [IDX_W-1:0] rb_idx,
    output logic [DATA_W-1:0] rb_data,
    // Write port
    input wire logic we,
    input wire logic [IDX_W-1:0] w_idx,
    input wire logic [DATA_W-1:0] w_data
);
    logic [DATA_W-1:0] mem_r [DEPTH];

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= oag_pkg::OAG_REG_RESET;
            end
            ra_data <= oag_pkg::OAG_REG_RESET;
            rb_data <= oag_pkg::OAG_REG_RESET;
        end else begin
            if (we) begin
                mem_r[w_idx] <= w_data;
            end
            ra_data <= mem_r[ra_idx];
            rb_data <= mem_r[rb_idx];
        end
    end
endmodule

// ### verif/oag_mem_model.sv
// Passive data and program memory model facing the address generator
`timescale 1ns/1ps
module oag_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Data memory side
    input wire logic mem_access,
    input wire logic [15:0] data_addr,
    // Program memory side
    input wire logic prog_access,
    input wire logic [23:0] prog_addr,
    // Access record for the bench
    output int n_data,
    output int n_prog,
    output logic [15:0] last_data,
    output logic [23:0] last_prog
);
    // Only records accesses; no read data path exists at these ports
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            n_data <= 0;
            n_prog <= 0;
            last_data <= 16'h0000;
            last_prog <= 24'h000000;
        end else begin
            if (mem_access) begin
                n_data <= n_data + 1;
                last_data <= data_addr;
            end
            if (prog_access) begin
                n_prog <= n_prog + 1;
                last_prog <= prog_addr;
            end
        end
    end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
module testbench;
    logic clk, rstn, req_valid, lit_long, byte_op, reg_we, page_we;
    logic [3:0] req_mode, ptr_idx, base_idx, reg_widx;
    logic [12:0] file_addr;
    logic [15:0] full_addr, reg_wdata;
    logic [9:0] lit_field;
    logic [1:0] tbl_kind;
    logic [7:0] page_wdata;
    logic res_valid, mem_access, prog_access, prog_high, prog_write;
    logic prog_byte;
    logic [15:0] data_addr, operand, base_operand, implied_operand;
    logic [23:0] prog_addr, lane_mask, last_prog;
    logic [15:0] last_data;
    int n_data, n_prog, n_mismatch, samples_checked, cyc;

    oag_top oag_top_i (.CLK(clk), .RSTN(rstn), .REQ_VALID(req_valid),
        .REQ_MODE(req_mode), .PTR_IDX(ptr_idx), .BASE_IDX(base_idx),
        .FILE_ADDR(file_addr), .FULL_ADDR(full_addr),
        .LIT_FIELD(lit_field), .LIT_LONG(lit_long), .BYTE_OP(byte_op),
        .TBL_KIND(tbl_kind), .REG_WE(reg_we), .REG_WIDX(reg_widx),
        .REG_WDATA(reg_wdata), .PAGE_WE(page_we), .PAGE_WDATA(page_wdata),
        .RES_VALID(res_valid), .MEM_ACCESS(mem_access),
        .DATA_ADDR(data_addr), .OPERAND(operand),
        .BASE_OPERAND(base_operand), .IMPLIED_OPERAND(implied_operand),
        .PROG_ACCESS(prog_access), .PROG_ADDR(prog_addr),
        .PROG_HIGH(prog_high), .PROG_WRITE(prog_write),
        .PROG_BYTE(prog_byte), .PROG_LANE_MASK(lane_mask));

    oag_mem_model oag_mem_model_i (.clk(clk), .rstn(rstn),
        .mem_access(mem_access), .data_addr(data_addr),
        .prog_access(prog_access), .prog_addr(prog_addr),
        .n_data(n_data), .n_prog(n_prog), .last_data(last_data),
        .last_prog(last_prog));

    // ----------------------------------------
    // Clock, timeout and verdict
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Shared drivers and compare
    // ----------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] idx, input logic [15:0] val);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_widx <= idx;
        reg_wdata <= val;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask

    // Request one cycle; the result pulse stands in the cycle after the
    // edge that follows the taking edge, so it is looked at right there
    task automatic go(input logic [3:0] m, input logic [3:0] p, b,
                      input logic bo, input logic [1:0] k);
        @(posedge clk);
        req_valid <= 1'b1;
        req_mode <= m;
        ptr_idx <= p;
        base_idx <= b;
        byte_op <= bo;
        tbl_kind <= k;
        @(posedge clk);
        req_valid <= 1'b0;
        @(posedge clk);
        #1;
        chk(res_valid, 1'b1);
    endtask

    task automatic rd(input logic [3:0] idx, output logic [15:0] val);
        go(4'h1, idx, 4'h0, 1'b0, 2'h0);
        val = operand;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_direct();
        logic [15:0] v;
        wr(4'h0, 16'h1234);
        wr(4'h5, 16'h5555);
        wr(4'h3, 16'hbeef);
        file_addr <= 13'h1abc;
        go(4'h0, 4'h5, 4'h5, 1'b0, 2'h0);
        chk(data_addr, 16'h1abc);
        chk(mem_access, 1'b1);
        chk(implied_operand, 16'h1234);
        full_addr <= 16'hfffe;
        go(4'ha, 4'h0, 4'h0, 1'b0, 2'h0);
        chk(data_addr, 16'hfffe);
        go(4'h1, 4'h3, 4'h5, 1'b0, 2'h0);
        chk(operand, 16'hbeef);
        chk(mem_access, 1'b0);
        go(4'h2, 4'h3, 4'h5, 1'b0, 2'h0);
        chk(base_operand, 16'h5555);
        chk(data_addr, 16'hbeef);
        @(posedge clk);
        #1;
        chk(last_data, 16'hbeef);
        rd(4'h3, v);
        chk(v, 16'hbeef);
    endtask

    task automatic t_literal();
        for (int l = 0; l < 2; l++) begin
            lit_field <= 10'h3ff;
            lit_long <= l[0];
            go(4'h9, 4'h0, 4'h0, 1'b0, 2'h0);
            chk(operand, l ? 16'h03ff : 16'h001f);
            chk(mem_access, 1'b0);
        end
    endtask

    task automatic t_modify();
        logic [15:0] v, nv, st;
        for (int m = 3; m < 7; m++) begin
            for (int b = 0; b < 2; b++) begin
                wr(4'h2, 16'h0100);
                st = b ? 16'h0001 : 16'h0002;
                nv = (m == 3 || m == 5) ? 16'h0100 + st : 16'h0100 - st;
                go(m[3:0], 4'h2, 4'h0, b[0], 2'h0);
                chk(data_addr, m < 5 ? 16'h0100 : nv);
                rd(4'h2, v);
                chk(v, nv);
            end
        end
    endtask

    task automatic t_offset();
        logic [15:0] v;
        wr(4'h4, 16'h1000);
        wr(4'h6, 16'h0234);
        go(4'h7, 4'h4, 4'h6, 1'b0, 2'h0);
        chk(data_addr, 16'h1234);
        rd(4'h4, v);
        chk(v, 16'h1000);
        rd(4'h6, v);
        chk(v, 16'h0234);
        for (int l = 0; l < 2; l++) begin
            lit_field <= 10'h3f5;
            lit_long <= l[0];
            go(4'h8, 4'h4, 4'h0, 1'b0, 2'h0);
            chk(data_addr, l ? 16'h13f5 : 16'h1015);
        end
    endtask

    task automatic t_table();
        @(posedge clk);
        page_we <= 1'b1;
        page_wdata <= 8'h5a;
        @(posedge clk);
        page_we <= 1'b0;
        wr(4'h7, 16'h8001);
        for (int k = 0; k < 4; k++) begin
            for (int b = 0; b < 2; b++) begin
                go(4'hb, 4'h7, 4'h0, b[0], k[1:0]);
                chk(prog_access, 1'b1);
                chk(prog_addr, 24'h5a8001);
                chk(prog_high, k[1]);
                chk(prog_write, k[0]);
                chk(prog_byte, b[0]);
                chk(lane_mask, k[1] ? 24'hff0000 :
                    (b ? 24'h00ff00 : 24'h00ffff));
            end
        end
        wr(4'h7, 16'h8000);
        go(4'hb, 4'h7, 4'h0, 1'b1, 2'h1);
        chk(lane_mask, 24'h0000ff);
        @(posedge clk);
        #1;
        chk(last_prog, 24'h5a8000);
        chk(n_prog, 24'h000009);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_mode = 4'h0;
        ptr_idx = 4'h0;
        base_idx = 4'h0;
        file_addr = 13'h0000;
        full_addr = 16'h0000;
        lit_field = 10'h000;
        lit_long = 1'b0;
        byte_op = 1'b0;
        tbl_kind = 2'h0;
        reg_we = 1'b0;
        reg_widx = 4'h0;
        reg_wdata = 16'h0000;
        page_we = 1'b0;
        page_wdata = 8'h00;
        repeat (20) @(posedge clk);
        #1;
        chk(res_valid, 1'b0);
        rstn <= 1'b1;
        t_direct();
        t_literal();
        t_modify();
        t_offset();
        t_table();
        tally_and_finish();
    end
endmodule
